// >>> hbpc_pkg.sv
// Constants for the host bus pin control block.
// Assumes a single machine clock and a synchronous active-high reset.
package hbpc_pkg;
  localparam logic [1:0] HBPC_BUS_SWITCH_CONTROL_REG_ADDR = 2'h0;
  localparam int HBPC_EXT_KEEP_BIT = 0;
  localparam int HBPC_HOST_KEEP_BIT = 1;
  localparam logic [1:0] HBPC_BUS_SWITCH_CONTROL_REG_RESET = 2'h0;
  localparam int HBPC_DATA_W = 16;
  localparam int HBPC_ADDR_W = 16;
  localparam int HBPC_HOST_W = 8;
endpackage : hbpc_pkg

// >>> hbpc_top.sv
// Pin control for the external address/data pins and the host byte data pins.
// Assumes the core supplies drive requests and data; pads resolve the wires from the enables.
// Notes on behaviour
// - Wide host mode lets external address pins select internal memory for host port.
// - Wide host mode carries 16-bit host data on external data pins, else CPU transfers.
// - External data pins float unless driving, and under reset, hold request or float.
// - Undriven external data pins with keeper on hold the last driven level.
// - External keeper is off at reset and set by its control register bit.
// - Host byte pins are the host data bus, or general I/O in wide host mode.
// - Host byte pins float unless driving and whenever the float input is low.
// - Undriven host byte pins with keeper on hold the last driven level.
// - Host keeper is off at reset and set by its control register bit.
`timescale 1ns/10ps
module hbpc_top
  import hbpc_pkg::*;
#(
  parameter int DW = HBPC_DATA_W,
  parameter int AW = HBPC_ADDR_W,
  parameter int HW = HBPC_HOST_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [1:0] reg_rdata,
  // Mode and float pins
  input wire logic wide_host_mode_pin,
  input wire logic bus_hold_req,
  input wire logic global_float_n,
  // External address pins
  input wire logic [AW-1:0] ext_address_pins_i,
  output logic [AW-1:0] host_port_addr,
  output logic host_port_addr_valid,
  // External data pins
  input wire logic [DW-1:0] ext_data_pins_i,
  output logic [DW-1:0] ext_data_pins_o,
  output logic ext_data_pins_oe,
  output logic ext_data_keep_en,
  // Core side of the external data bus
  input wire logic cpu_drive,
  input wire logic [DW-1:0] cpu_wdata,
  input wire logic host_port_drive,
  input wire logic [DW-1:0] host_port_rdata,
  output logic [DW-1:0] cpu_rdata,
  output logic [DW-1:0] host_port_wdata,
  // Host byte data pins
  input wire logic [HW-1:0] host_byte_data_pins_i,
  output logic [HW-1:0] host_byte_data_pins_o,
  output logic [HW-1:0] host_byte_data_pins_oe,
  output logic host_byte_keep_en,
  // Core side of the host byte pins
  input wire logic host_byte_drive,
  input wire logic [HW-1:0] host_byte_wdata,
  input wire logic [HW-1:0] gpio_dir,
  input wire logic [HW-1:0] gpio_out,
  output logic [HW-1:0] host_byte_rdata,
  output logic [HW-1:0] gpio_in
);
  logic [1:0] bus_switch_control_reg_q, bus_switch_control_reg_d;
  logic [1:0] rdata_q, rdata_d;
  logic [2:0] wide_s_q, wide_s_d;
  logic [2:0] hold_s_q, hold_s_d;
  logic [2:0] flt_s_q, flt_s_d;
  logic wide_q, wide_d, hold_q, hold_d, flt_n_q, flt_n_d;
  logic [DW-1:0] ed_o_q, ed_o_d, ed_i_q, ed_i_d, ed_m_q, ed_m_d, ed_c_q, ed_c_d, ed_h_q, ed_h_d;
  logic [AW-1:0] ad_q, ad_d;
  logic ad_v_q, ad_v_d, ed_oe_q, ed_oe_d;
  logic [HW-1:0] hb_o_q, hb_o_d, hb_oe_q, hb_oe_d, hb_i_q, hb_i_d, hb_m_q, hb_m_d;
  logic [HW-1:0] hb_r_q, hb_r_d, hb_g_q, hb_g_d;

  // Three-stage sampler; a change counts once the last two stages agree.
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction : filt

  always_comb
  begin
    bus_switch_control_reg_d = bus_switch_control_reg_q;
    rdata_d = rdata_q;
    if (reg_wr && reg_addr == HBPC_BUS_SWITCH_CONTROL_REG_ADDR)
    begin
      bus_switch_control_reg_d = reg_wdata;
    end
    if (reg_rd)
    begin
      rdata_d = (reg_addr == HBPC_BUS_SWITCH_CONTROL_REG_ADDR) ? bus_switch_control_reg_q : 2'h0;
    end
    wide_s_d = {wide_s_q[1:0], wide_host_mode_pin};
    hold_s_d = {hold_s_q[1:0], bus_hold_req};
    flt_s_d = {flt_s_q[1:0], global_float_n};
    wide_d = filt(wide_s_q, wide_q);
    hold_d = filt(hold_s_q, hold_q);
    flt_n_d = filt(flt_s_q, flt_n_q);
  end

  always_comb
  begin
    ed_i_d = ext_data_pins_i;
    ad_d = ext_address_pins_i;
    ad_v_d = wide_q;
    ed_oe_d = 1'b0;
    ed_o_d = ed_o_q;
    if (!hold_q && flt_n_q)
    begin
      if (wide_q && host_port_drive)
      begin
        ed_oe_d = 1'b1;
        ed_o_d = host_port_rdata;
      end
      else if (!wide_q && cpu_drive)
      begin
        ed_oe_d = 1'b1;
        ed_o_d = cpu_wdata;
      end
    end
    ed_m_d = ed_oe_d ? ed_o_d : ed_m_q;
    ed_c_d = wide_q ? ed_c_q : ed_i_q;
    ed_h_d = wide_q ? ed_i_q : ed_h_q;
    hb_i_d = host_byte_data_pins_i;
    hb_oe_d = '0;
    hb_o_d = hb_o_q;
    if (flt_n_q)
    begin
      if (wide_q)
      begin
        hb_oe_d = gpio_dir;
        hb_o_d = gpio_out;
      end
      else if (host_byte_drive)
      begin
        hb_oe_d = '1;
        hb_o_d = host_byte_wdata;
      end
    end
    for (int i = 0; i < HW; i++)
    begin
      hb_m_d[i] = hb_oe_d[i] ? hb_o_d[i] : hb_m_q[i];
    end
    hb_r_d = wide_q ? hb_r_q : hb_i_q;
    hb_g_d = wide_q ? hb_i_q : hb_g_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bus_switch_control_reg_q <= HBPC_BUS_SWITCH_CONTROL_REG_RESET;
      rdata_q <= 2'h0;
      wide_s_q <= 3'h0;
      hold_s_q <= 3'h0;
      flt_s_q <= 3'h7;
      wide_q <= 1'b0;
      hold_q <= 1'b0;
      flt_n_q <= 1'b1;
      ed_o_q <= '0;
      ed_oe_q <= 1'b0;
      ed_i_q <= '0;
      ed_m_q <= '0;
      ed_c_q <= '0;
      ed_h_q <= '0;
      ad_q <= '0;
      ad_v_q <= 1'b0;
      hb_o_q <= '0;
      hb_oe_q <= '0;
      hb_i_q <= '0;
      hb_m_q <= '0;
      hb_r_q <= '0;
      hb_g_q <= '0;
    end
    else
    begin
      bus_switch_control_reg_q <= bus_switch_control_reg_d;
      rdata_q <= rdata_d;
      wide_s_q <= wide_s_d;
      hold_s_q <= hold_s_d;
      flt_s_q <= flt_s_d;
      wide_q <= wide_d;
      hold_q <= hold_d;
      flt_n_q <= flt_n_d;
      ed_o_q <= ed_o_d;
      ed_oe_q <= ed_oe_d;
      ed_i_q <= ed_i_d;
      ed_m_q <= ed_m_d;
      ed_c_q <= ed_c_d;
      ed_h_q <= ed_h_d;
      ad_q <= ad_d;
      ad_v_q <= ad_v_d;
      hb_o_q <= hb_o_d;
      hb_oe_q <= hb_oe_d;
      hb_i_q <= hb_i_d;
      hb_m_q <= hb_m_d;
      hb_r_q <= hb_r_d;
      hb_g_q <= hb_g_d;
    end
  end

  // Pin levels show the driven value, or else the last driven level that the keeper holds.
  assign reg_rdata = rdata_q;
  assign host_port_addr = ad_q;
  assign host_port_addr_valid = ad_v_q;
  assign ext_data_pins_o = ed_m_q;
  assign ext_data_pins_oe = ed_oe_q;
  assign ext_data_keep_en = bus_switch_control_reg_q[HBPC_EXT_KEEP_BIT];
  assign cpu_rdata = ed_c_q;
  assign host_port_wdata = ed_h_q;
  assign host_byte_data_pins_o = hb_m_q;
  assign host_byte_data_pins_oe = hb_oe_q;
  assign host_byte_keep_en = bus_switch_control_reg_q[HBPC_HOST_KEEP_BIT];
  assign host_byte_rdata = hb_r_q;
  assign gpio_in = hb_g_q;

  sequence s_ext_release;
    ed_oe_q ##1 !ed_oe_q;
  endsequence : s_ext_release

  sequence s_host_release;
    host_byte_data_pins_oe[0] ##1 !host_byte_data_pins_oe[0];
  endsequence : s_host_release

  // Float and drive checks.
  a_reset_float: assert property (@(posedge core_clk)
    rst |=> (!ext_data_pins_oe && host_byte_data_pins_oe == '0))
    else $error("pins driven during reset");
  a_ext_float: assert property (@(posedge core_clk) disable iff (rst)
    (hold_q || !flt_n_q) |=> !ext_data_pins_oe)
    else $error("ext data driven while floated");
  a_ext_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!cpu_drive && !host_port_drive) |=> !ext_data_pins_oe)
    else $error("ext data driven without request");
  a_host_float: assert property (@(posedge core_clk) disable iff (rst)
    !flt_n_q |=> (host_byte_data_pins_oe == '0))
    else $error("host bytes driven while floated");
  a_host_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!wide_q && !host_byte_drive) |=> (host_byte_data_pins_oe == '0))
    else $error("host bytes driven without request");
  a_narrow_src: assert property (@(posedge core_clk) disable iff (rst)
    (!wide_q && cpu_drive && !hold_q && flt_n_q) |=> (ext_data_pins_oe && ext_data_pins_o == $past(cpu_wdata)))
    else $error("cpu data not driven");
  a_wide_src: assert property (@(posedge core_clk) disable iff (rst)
    (wide_q && host_port_drive && !hold_q && flt_n_q) |=> (ext_data_pins_oe && ext_data_pins_o == $past(host_port_rdata)))
    else $error("host port data not driven");
  a_wide_blocks: assert property (@(posedge core_clk) disable iff (rst)
    (wide_q && !host_port_drive) |=> !ext_data_pins_oe)
    else $error("ext data driven by cpu in wide mode");
  a_host_drive: assert property (@(posedge core_clk) disable iff (rst)
    (!wide_q && host_byte_drive && flt_n_q) |=> (host_byte_data_pins_oe == '1 && host_byte_data_pins_o == $past(host_byte_wdata)))
    else $error("host byte data not driven");
  a_gpio_dir: assert property (@(posedge core_clk) disable iff (rst)
    (wide_q && flt_n_q) |=> (host_byte_data_pins_oe == $past(gpio_dir)))
    else $error("gpio direction wrong");
  a_gpio_out: assert property (@(posedge core_clk) disable iff (rst)
    (wide_q && flt_n_q) |=> ((host_byte_data_pins_o & host_byte_data_pins_oe) == ($past(gpio_out) & $past(gpio_dir))))
    else $error("gpio output level wrong");

  // Keeper checks.
  a_ext_keep: assert property (@(posedge core_clk) disable iff (rst)
    s_ext_release |-> (ext_data_pins_o == $past(ed_o_q)))
    else $error("ext keeper lost level");
  a_host_keep: assert property (@(posedge core_clk) disable iff (rst)
    s_host_release |-> (host_byte_data_pins_o[0] == $past(hb_o_q[0])))
    else $error("host keeper lost level");
  a_keep_reset: assert property (@(posedge core_clk)
    rst |=> (!ext_data_keep_en && !host_byte_keep_en))
    else $error("keepers on after reset");
  a_keep_write: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == HBPC_BUS_SWITCH_CONTROL_REG_ADDR) |=> ({host_byte_keep_en, ext_data_keep_en} == $past(reg_wdata)))
    else $error("keeper bits not updated");
  a_keep_hold: assert property (@(posedge core_clk) disable iff (rst)
    !reg_wr |=> $stable({ext_data_keep_en, host_byte_keep_en}))
    else $error("keeper bits changed without write");

  // Sampling checks.
  a_addr_mode: assert property (@(posedge core_clk) disable iff (rst)
    wide_q |=> host_port_addr_valid)
    else $error("address not valid in wide mode");
  a_addr_idle: assert property (@(posedge core_clk) disable iff (rst)
    !wide_q |=> !host_port_addr_valid)
    else $error("address valid in narrow mode");
  a_addr_capture: assert property (@(posedge core_clk) disable iff (rst)
    wide_q |=> (host_port_addr == $past(ext_address_pins_i)))
    else $error("host port address not captured");
  a_cpu_rdata: assert property (@(posedge core_clk) disable iff (rst)
    !wide_q |=> (cpu_rdata == $past(ed_i_q)))
    else $error("cpu read data not captured");
  a_hp_wdata: assert property (@(posedge core_clk) disable iff (rst)
    wide_q |=> (host_port_wdata == $past(ed_i_q)))
    else $error("host port write data not captured");
  a_host_rdata: assert property (@(posedge core_clk) disable iff (rst)
    !wide_q |=> (host_byte_rdata == $past(hb_i_q)))
    else $error("host byte data not captured");
  a_gpio_in: assert property (@(posedge core_clk) disable iff (rst)
    wide_q |=> (gpio_in == $past(hb_i_q)))
    else $error("gpio input not captured");

  // Register port checks.
  a_rd_data: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd |=> (reg_rdata == (($past(reg_addr) == HBPC_BUS_SWITCH_CONTROL_REG_ADDR) ? $past(bus_switch_control_reg_q) : 2'h0)))
    else $error("register read data wrong");
  a_rd_hold: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("register read data changed without read");
  a_unmapped_wr: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr != HBPC_BUS_SWITCH_CONTROL_REG_ADDR) |=> $stable(bus_switch_control_reg_q))
    else $error("unmapped write changed control bits");
endmodule : hbpc_top

// >>> hbpc_far_model.sv
// Far-side model of one pin group: external devices and the wire itself.
// Assumes device enables and levels change on the machine clock.
`timescale 1ns/10ps
module hbpc_far_model
  import hbpc_pkg::*;
#(
  parameter int W = 16
) (
  // Clock
  input wire logic core_clk,
  // Far-side drive
  input wire logic drive,
  input wire logic [W-1:0] val,
  // Device side
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] o,
  input wire logic keep,
  // Resolved wire
  output logic [W-1:0] pins
);
  logic [W-1:0] last_q = '0;
  logic [W-1:0] idle;
  always @(posedge core_clk) last_q <= pins;
  // A floating wire without keeper shows a pattern that changes every cycle.
  assign idle = keep ? o : ~last_q;
  assign pins = drive ? val : ((oe & o) | (~oe & idle));
endmodule : hbpc_far_model

// >>> tb.sv
// Self-checking bench for the host bus pin control block.
// Assumes far-side models resolve both pin groups.
`timescale 1ns/10ps
module tb
  import hbpc_pkg::*;
;
  logic core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, wide_host_mode_pin = 1'h0;
  logic bus_hold_req = 1'h0, global_float_n = 1'h1, cpu_drive = 1'h0, host_port_drive = 1'h0;
  logic host_byte_drive = 1'h0, fx_drv = 1'h0, fh_drv = 1'h0;
  logic host_port_addr_valid, ext_data_pins_oe, ext_data_keep_en, host_byte_keep_en;
  logic [1:0] reg_addr = 2'h0, reg_wdata = 2'h0, reg_rdata;
  logic [15:0] ext_address_pins_i = 16'h0, cpu_wdata = 16'h0, host_port_rdata = 16'h0, fx_val = 16'h0;
  logic [15:0] host_port_addr, ext_data_pins_i, ext_data_pins_o, cpu_rdata, host_port_wdata;
  logic [7:0] host_byte_wdata = 8'h0, gpio_dir = 8'h0, gpio_out = 8'h0, fh_val = 8'h0;
  logic [7:0] host_byte_data_pins_i, host_byte_data_pins_o, host_byte_data_pins_oe, host_byte_rdata, gpio_in;
  int fail_count = 0, checked = 0;
  hbpc_top hbpc_top_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wide_host_mode_pin(wide_host_mode_pin),
    .bus_hold_req(bus_hold_req), .global_float_n(global_float_n), .ext_address_pins_i(ext_address_pins_i),
    .host_port_addr(host_port_addr), .host_port_addr_valid(host_port_addr_valid),
    .ext_data_pins_i(ext_data_pins_i), .ext_data_pins_o(ext_data_pins_o), .ext_data_pins_oe(ext_data_pins_oe),
    .ext_data_keep_en(ext_data_keep_en), .cpu_drive(cpu_drive), .cpu_wdata(cpu_wdata),
    .host_port_drive(host_port_drive), .host_port_rdata(host_port_rdata), .cpu_rdata(cpu_rdata),
    .host_port_wdata(host_port_wdata), .host_byte_data_pins_i(host_byte_data_pins_i),
    .host_byte_data_pins_o(host_byte_data_pins_o), .host_byte_data_pins_oe(host_byte_data_pins_oe),
    .host_byte_keep_en(host_byte_keep_en), .host_byte_drive(host_byte_drive),
    .host_byte_wdata(host_byte_wdata), .gpio_dir(gpio_dir), .gpio_out(gpio_out),
    .host_byte_rdata(host_byte_rdata), .gpio_in(gpio_in));
  hbpc_far_model hbpc_far_model_inst (.core_clk(core_clk), .drive(fx_drv), .val(fx_val),
    .oe({16{ext_data_pins_oe}}), .o(ext_data_pins_o), .keep(ext_data_keep_en), .pins(ext_data_pins_i));
  hbpc_far_model #(.W(8)) hbpc_far_model_hb_inst (.core_clk(core_clk), .drive(fh_drv), .val(fh_val),
    .oe(host_byte_data_pins_oe), .o(host_byte_data_pins_o), .keep(host_byte_keep_en), .pins(host_byte_data_pins_i));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [1:0] a, input logic [1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, input logic [1:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask : reg_read
  task automatic t_keepers();
    #1 chk(16'({ext_data_pins_oe, host_byte_data_pins_oe}), 16'h0);
    reg_read(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, HBPC_BUS_SWITCH_CONTROL_REG_RESET);
    reg_write(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h1);
    #1 chk(16'({ext_data_keep_en, host_byte_keep_en}), 16'h2);
    reg_write(2'h2, 2'h2);
    reg_read(2'h2, 2'h0);
    reg_read(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h1);
    reg_write(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h2);
    #1 chk(16'({ext_data_keep_en, host_byte_keep_en}), 16'h1);
    reg_write(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h3);
    reg_read(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h3);
  endtask : t_keepers
  task automatic t_reset();
    @(posedge core_clk);
    cpu_drive <= 1'h1;
    host_byte_drive <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1 chk(16'({ext_data_pins_oe, host_byte_data_pins_oe}), 16'h1ff);
    @(posedge core_clk);
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1 chk(16'({ext_data_keep_en, host_byte_keep_en, ext_data_pins_oe, host_byte_data_pins_oe}), 16'h0);
    @(posedge core_clk);
    cpu_drive <= 1'h0;
    host_byte_drive <= 1'h0;
    @(posedge core_clk);
    rst <= 1'h0;
    reg_read(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, HBPC_BUS_SWITCH_CONTROL_REG_RESET);
    reg_write(HBPC_BUS_SWITCH_CONTROL_REG_ADDR, 2'h3);
    #1 chk(16'({ext_data_keep_en, host_byte_keep_en}), 16'h3);
  endtask : t_reset
  task automatic t_narrow();
    cpu_wdata <= 16'ha55a;
    cpu_drive <= 1'h1;
    host_byte_wdata <= 8'h3c;
    host_byte_drive <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1 chk(ext_data_pins_o, 16'ha55a);
    chk(16'(host_port_addr_valid), 16'h0);
    chk({host_byte_data_pins_oe, host_byte_data_pins_o}, 16'hff3c);
    @(posedge core_clk);
    cpu_drive <= 1'h0;
    host_byte_drive <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1 chk(16'(ext_data_pins_oe), 16'h0);
    chk(ext_data_pins_i, 16'ha55a);
    chk(16'(host_byte_data_pins_i), 16'h3c);
    @(posedge core_clk);
    fx_val <= 16'h1234;
    fx_drv <= 1'h1;
    fh_val <= 8'hc3;
    fh_drv <= 1'h1;
    repeat (4) @(posedge core_clk);
    #1 chk(cpu_rdata, 16'h1234);
    chk(16'(host_byte_rdata), 16'hc3);
    @(posedge core_clk);
    fx_drv <= 1'h0;
    fh_drv <= 1'h0;
    cpu_drive <= 1'h1;
    host_byte_drive <= 1'h1;
    bus_hold_req <= 1'h1;
    repeat (8) @(posedge core_clk);
    #1 chk(16'({ext_data_pins_oe, host_byte_data_pins_oe}), 16'hff);
    @(posedge core_clk);
    bus_hold_req <= 1'h0;
    global_float_n <= 1'h0;
    repeat (8) @(posedge core_clk);
    #1 chk(16'({ext_data_pins_oe, host_byte_data_pins_oe}), 16'h0);
    @(posedge core_clk);
    global_float_n <= 1'h1;
    cpu_drive <= 1'h0;
    host_byte_drive <= 1'h0;
  endtask : t_narrow
  task automatic t_wide();
    wide_host_mode_pin <= 1'h1;
    ext_address_pins_i <= 16'hbeef;
    host_port_rdata <= 16'h5aa5;
    host_port_drive <= 1'h1;
    repeat (8) @(posedge core_clk);
    #1 chk(host_port_addr, 16'hbeef);
    chk(16'(host_port_addr_valid), 16'h1);
    chk(ext_data_pins_o, 16'h5aa5);
    @(posedge core_clk);
    host_port_drive <= 1'h0;
    fx_val <= 16'h0ff0;
    fx_drv <= 1'h1;
    fh_val <= 8'h77;
    fh_drv <= 1'h1;
    repeat (4) @(posedge core_clk);
    #1 chk(host_port_wdata, 16'h0ff0);
    chk(16'(gpio_in), 16'h77);
    @(posedge core_clk);
    fx_drv <= 1'h0;
    fh_drv <= 1'h0;
    gpio_dir <= 8'h0f;
    gpio_out <= 8'ha5;
    repeat (2) @(posedge core_clk);
    #1 chk({host_byte_data_pins_oe, host_byte_data_pins_o & 8'h0f}, 16'h0f05);
  endtask : t_wide
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_keepers();
    t_reset();
    @(posedge core_clk);
    t_narrow();
    @(posedge core_clk);
    t_wide();
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb
